// [verilog/vec_unit.sv]
// Notes on behaviour
// - Opcode 145 ORs paired elements into result
// - Process exactly vector-length elements, independently
// - OR issues when regs and unit free
// - OR timing: next 2, dest 21, src 17, unit 22
// - Add clock per element past 1 or 4
// - Opcode 146 merges held scalar by mask
// - Mask consumed from most significant bit
// - Scalar merge issues when scalar, mask copy, regs, unit free
// - Scalar merge timing: dest 21, src 17, unit 22
// - Opcode 147 merges two vectors by mask
// - Vector merge issues when mask copy, regs, unit free
// - Vector merge next instruction at phase 5
// - Opcode 150 shifts elements left, zero fill
// - Count held, unsigned 32-bit, large gives zero
// - Shift issues when count, regs, unit free
// - Shift timing: dest 27, src 17, unit 20
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module vec_fifo #(
    parameter int W     = 64,
    parameter int DEPTH = 16
) (
    input  wire logic         CLK,
    input  wire logic         SYS_RST,
    input  wire logic         IN_VALID,
    output logic              IN_READY,
    input  wire logic [W-1:0] IN_DATA,
    output logic              OUT_VALID,
    input  wire logic         OUT_READY,
    output logic [W-1:0]      OUT_DATA
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   fill;
    } fifo_state_t;

    fifo_state_t     s_r;
    fifo_state_t     s_nxt;
    logic [W-1:0]    mem [DEPTH];
    logic            push;
    logic            pop;

    assign IN_READY  = (s_r.fill != (AW+1)'(DEPTH));
    assign OUT_VALID = (s_r.fill != '0);
    assign OUT_DATA  = mem[s_r.rd];
    assign push      = IN_VALID && IN_READY;
    assign pop       = OUT_VALID && OUT_READY;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.wr = (s_r.wr == AW'(DEPTH-1)) ? '0 : s_r.wr + 1'b1;
        end
        if (pop) begin
            s_nxt.rd = (s_r.rd == AW'(DEPTH-1)) ? '0 : s_r.rd + 1'b1;
        end
        s_nxt.fill = s_r.fill + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage needs no reset; fill count guards it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
        if (push) begin
            mem[s_r.wr] <= IN_DATA;
        end
    end
endmodule : vec_fifo

////////////////////////////////////////////////////////////////////////////////
module vec_unit
    import vec_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    vec_link_if.unit         link,
    output logic             UNIT_ACTIVE,
    output logic [LEN_W-1:0] ELEMS_DONE
);
    import vec_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_DRAIN = 2'b10
    } ust_t;

    typedef struct packed {
        ust_t              st;
        vop_t              op;
        logic [LEN_W-1:0]  len;
        logic [LEN_W-1:0]  taken;
        logic [LEN_W-1:0]  given;
        logic [TMR_W-1:0]  clk_cnt;
        logic [WORD_W-1:0] scalar;
        logic [WORD_W-1:0] mask;
        logic [CNT_W-1:0]  count;
        logic              src_done;
        logic              dst_done;
        logic              src_rel;
        logic              dst_rdy;
    } unit_state_t;

    unit_state_t       s_r;
    unit_state_t       s_nxt;
    logic              take;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic [WORD_W-1:0] result;
    logic              is_shift;
    logic [TMR_W-1:0]  dl_src;
    logic [TMR_W-1:0]  dl_dst;
    logic [TMR_W-1:0]  dl_free;

    ////////////////////////////////////////////////////////////////////////////
    // Element datapath
    always_comb begin
        unique case (s_r.op)
            OP_OR:     result = link.src_a | link.src_b;
            OP_MRG_SV: result = s_r.mask[WORD_W-1] ? s_r.scalar : link.src_b;
            OP_MRG_VV: result = s_r.mask[WORD_W-1] ? link.src_a : link.src_b;
            OP_SHL: begin
                // Count of 64 or more leaves nothing but zeros
                if (s_r.count >= CNT_W'(SHIFT_LIMIT)) begin
                    result = '0;
                end else begin
                    result = link.src_a << s_r.count[5:0];
                end
            end
        endcase
    end

    // Source pairs stall while the result buffer is full
    assign take = (s_r.st == ST_RUN) && (s_r.taken != s_r.len)
                  && link.src_valid && fifo_in_ready;
    assign link.src_ready = (s_r.st == ST_RUN) && (s_r.taken != s_r.len) && fifo_in_ready;

    vec_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_res_fifo (
        .CLK       (CLK),
        .SYS_RST   (SYS_RST),
        .IN_VALID  (take),
        .IN_READY  (fifo_in_ready),
        .IN_DATA   (result),
        .OUT_VALID (fifo_out_valid),
        .OUT_READY (link.res_ready),
        .OUT_DATA  (fifo_out_data)
    );

    assign link.res_valid = fifo_out_valid;
    assign link.res_data  = fifo_out_data;
    assign link.res_last  = fifo_out_valid && (s_r.given == s_r.len - 1'b1);

    ////////////////////////////////////////////////////////////////////////////
    // Completion deadlines in clocks since the operation was taken
    assign is_shift = (s_r.op == OP_SHL);
    assign dl_src   = deadline(SRC_REL_PH, s_r.len, REL_BASE_LEN);
    assign dl_dst   = is_shift ? deadline(SU_DST_PH, s_r.len, DST_BASE_LEN)
                               : deadline(LU_DST_PH, s_r.len, DST_BASE_LEN);
    assign dl_free  = is_shift ? deadline(SU_FREE_PH, s_r.len, REL_BASE_LEN)
                               : deadline(LU_FREE_PH, s_r.len, REL_BASE_LEN);

    always_comb begin
        s_nxt         = s_r;
        s_nxt.src_rel = 1'b0;
        s_nxt.dst_rdy = 1'b0;
        unique case (s_r.st)
            ST_IDLE: begin
                if (link.op_valid) begin
                    s_nxt.st       = ST_RUN;
                    s_nxt.op       = link.op_code;
                    s_nxt.len      = link.op_len;
                    s_nxt.scalar   = link.op_scalar;
                    s_nxt.mask     = link.op_mask;
                    s_nxt.count    = link.op_count;
                    s_nxt.taken    = '0;
                    s_nxt.given    = '0;
                    s_nxt.clk_cnt  = '0;
                    s_nxt.src_done = 1'b0;
                    s_nxt.dst_done = 1'b0;
                end
            end
            ST_RUN, ST_DRAIN: begin
                if (s_r.clk_cnt != '1) begin
                    s_nxt.clk_cnt = s_r.clk_cnt + 1'b1;
                end
                if (take) begin
                    s_nxt.taken = s_r.taken + 1'b1;
                    s_nxt.mask  = {s_r.mask[WORD_W-2:0], 1'b0};
                end
                if (link.res_valid && link.res_ready) begin
                    s_nxt.given = s_r.given + 1'b1;
                end
                // Release never precedes the data it covers
                if (!s_r.src_done && s_r.clk_cnt >= dl_src - 1'b1
                    && s_r.taken == s_r.len) begin
                    s_nxt.src_done = 1'b1;
                    s_nxt.src_rel  = 1'b1;
                end
                if (!s_r.dst_done && s_r.clk_cnt >= dl_dst - 1'b1
                    && s_r.given == s_r.len) begin
                    s_nxt.dst_done = 1'b1;
                    s_nxt.dst_rdy  = 1'b1;
                end
                if (s_r.taken == s_r.len) begin
                    s_nxt.st = ST_DRAIN;
                end
                if (s_r.st == ST_DRAIN && s_r.src_done && s_r.dst_done
                    && s_r.clk_cnt >= dl_free - 1'b1) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Resource state seen by the issue logic
    assign link.op_ready   = (s_r.st == ST_IDLE);
    assign link.lu_busy    = (s_r.st != ST_IDLE) && !is_shift;
    assign link.su_busy    = (s_r.st != ST_IDLE) && is_shift;
    assign link.mask_busy  = (s_r.st != ST_IDLE)
                             && (s_r.op == OP_MRG_SV || s_r.op == OP_MRG_VV);
    assign link.src_release = s_r.src_rel;
    assign link.dst_ready   = s_r.dst_rdy;
    assign UNIT_ACTIVE      = (s_r.st != ST_IDLE);
    assign ELEMS_DONE       = s_r.given;
endmodule : vec_unit

// [inc/vec_pkg.sv]
package vec_pkg;

    localparam int WORD_W     = 64;
    localparam int LEN_W      = 7;
    localparam int CNT_W      = 32;
    localparam int TMR_W      = 8;
    localparam int NREG       = 8;
    localparam int FIFO_DEPTH = 16;

    // Opcodes, octal 145..150
    localparam logic [8:0] OPC_OR     = 9'h065;
    localparam logic [8:0] OPC_MRG_SV = 9'h066;
    localparam logic [8:0] OPC_MRG_VV = 9'h067;
    localparam logic [8:0] OPC_SHL    = 9'h068;

    // Timing in half-clock phases, as printed
    localparam int PH_PER_CLK   = 2;
    localparam int NEXT_PH      = 2;
    localparam int NEXT_VV_PH   = 5;
    localparam int SRC_REL_PH   = 17;
    localparam int LU_DST_PH    = 21;
    localparam int LU_FREE_PH   = 22;
    localparam int SU_DST_PH    = 27;
    localparam int SU_FREE_PH   = 20;
    localparam int DST_BASE_LEN = 1;
    localparam int REL_BASE_LEN = 4;
    localparam int SHIFT_LIMIT  = 64;

    // Phase to whole clocks, rounded up, at least one
    function automatic logic [TMR_W-1:0] ph2clk(input int ph);
        int c;
        c = (ph + PH_PER_CLK - 1) / PH_PER_CLK;
        if (c < 1) begin
            c = 1;
        end
        return TMR_W'(c);
    endfunction : ph2clk

    localparam logic [1:0] NEXT_CLK    = 2'(ph2clk(NEXT_PH));
    localparam logic [1:0] NEXT_VV_CLK = 2'(ph2clk(NEXT_VV_PH));

    typedef enum logic [1:0] {
        OP_OR     = 2'b00,
        OP_MRG_SV = 2'b01,
        OP_MRG_VV = 2'b10,
        OP_SHL    = 2'b11
    } vop_t;

    // Clock count at which an event is due for a given length
    function automatic logic [TMR_W-1:0] deadline(input int ph, input logic [LEN_W-1:0] len,
                                                  input int base);
        logic [TMR_W-1:0] extra;
        extra = (int'(len) > base) ? TMR_W'(int'(len) - base) : '0;
        return ph2clk(ph) + extra;
    endfunction : deadline

endpackage : vec_pkg

// [inc/vec_link_if.sv]
`timescale 1ns/1ps
interface vec_link_if;
    import vec_pkg::*;
    // Operation from issue logic
    logic                 op_valid;
    logic                 op_ready;
    vop_t                 op_code;
    logic [LEN_W-1:0]     op_len;
    logic [WORD_W-1:0]    op_scalar;
    logic [WORD_W-1:0]    op_mask;
    logic [CNT_W-1:0]     op_count;
    // Source element pairs
    logic                 src_valid;
    logic                 src_ready;
    logic [WORD_W-1:0]    src_a;
    logic [WORD_W-1:0]    src_b;
    // Result elements
    logic                 res_valid;
    logic                 res_ready;
    logic [WORD_W-1:0]    res_data;
    logic                 res_last;
    // Resource state
    logic                 lu_busy;
    logic                 su_busy;
    logic                 mask_busy;
    logic                 src_release;
    logic                 dst_ready;

    modport unit (
        input  op_valid, op_code, op_len, op_scalar, op_mask, op_count,
        input  src_valid, src_a, src_b, res_ready,
        output op_ready, src_ready, res_valid, res_data, res_last,
        output lu_busy, su_busy, mask_busy, src_release, dst_ready
    );
    modport issue (
        output op_valid, op_code, op_len, op_scalar, op_mask, op_count,
        output src_valid, src_a, src_b, res_ready,
        input  op_ready, src_ready, res_valid, res_data, res_last,
        input  lu_busy, su_busy, mask_busy, src_release, dst_ready
    );
endinterface : vec_link_if

// [verilog/vec_issue.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module vec_issue
    import vec_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    vec_link_if.issue              link,
    input  wire logic              INS_VALID,
    output logic                   INS_READY,
    input  wire logic [8:0]        INS_OPCODE,
    input  wire logic [2:0]        INS_I,
    input  wire logic [2:0]        INS_J,
    input  wire logic [2:0]        INS_K,
    input  wire logic [LEN_W-1:0]  INS_LEN,
    input  wire logic [WORD_W-1:0] INS_SCALAR,
    input  wire logic [WORD_W-1:0] INS_MASK,
    input  wire logic [CNT_W-1:0]  INS_COUNT,
    input  wire logic              SCALAR_FREE,
    input  wire logic              COUNT_FREE,
    output logic                   ILLEGAL,
    input  wire logic              SRC_VALID,
    output logic                   SRC_READY,
    input  wire logic [WORD_W-1:0] SRC_A,
    input  wire logic [WORD_W-1:0] SRC_B,
    output logic                   RES_VALID,
    input  wire logic              RES_READY,
    output logic [WORD_W-1:0]      RES_DATA,
    output logic                   RES_LAST,
    output logic [NREG-1:0]        REG_BUSY
);
    import vec_pkg::*;

    typedef struct packed {
        logic [NREG-1:0]   busy;
        logic [NREG-1:0]   src_set;
        logic [NREG-1:0]   dst_set;
        logic [1:0]        holdoff;
        logic              illegal;
        logic              op_valid;
        vop_t              op_code;
        logic [LEN_W-1:0]  op_len;
        logic [WORD_W-1:0] op_scalar;
        logic [WORD_W-1:0] op_mask;
        logic [CNT_W-1:0]  op_count;
    } iss_state_t;

    iss_state_t      s_r;
    iss_state_t      s_nxt;
    logic            known;
    logic            can_go;
    logic            fire;
    vop_t            dec_op;
    logic [NREG-1:0] need_src;
    logic [NREG-1:0] need_dst;

    ////////////////////////////////////////////////////////////////////////////
    // Decode and resource check
    always_comb begin
        known    = 1'b1;
        dec_op   = OP_OR;
        need_src = '0;
        need_dst = NREG'(1) << INS_I;
        can_go   = 1'b0;
        unique case (INS_OPCODE)
            OPC_OR: begin
                need_src = (NREG'(1) << INS_J) | (NREG'(1) << INS_K);
                can_go   = !link.lu_busy;
            end
            OPC_MRG_SV: begin
                dec_op   = OP_MRG_SV;
                need_src = NREG'(1) << INS_K;
                can_go   = SCALAR_FREE && !link.lu_busy && !link.mask_busy;
            end
            OPC_MRG_VV: begin
                dec_op   = OP_MRG_VV;
                need_src = (NREG'(1) << INS_J) | (NREG'(1) << INS_K);
                can_go   = !link.lu_busy && !link.mask_busy;
            end
            OPC_SHL: begin
                dec_op   = OP_SHL;
                need_src = NREG'(1) << INS_J;
                can_go   = COUNT_FREE && !link.su_busy;
            end
            default: known = 1'b0;
        endcase
        // Unit serialises work, so both units must be idle
        can_go = can_go && !link.lu_busy && !link.su_busy
                 && ((need_src | need_dst) & s_r.busy) == '0;
    end

    assign INS_READY = !s_r.op_valid && s_r.holdoff == '0 && (!known || can_go);
    assign fire      = INS_VALID && INS_READY;

    always_comb begin
        s_nxt         = s_r;
        s_nxt.illegal = 1'b0;
        if (s_r.holdoff != '0) begin
            s_nxt.holdoff = s_r.holdoff - 1'b1;
        end
        if (s_r.op_valid && link.op_ready) begin
            s_nxt.op_valid = 1'b0;
        end
        if (link.src_release) begin
            s_nxt.busy = s_nxt.busy & ~s_r.src_set;
        end
        if (link.dst_ready) begin
            s_nxt.busy = s_nxt.busy & ~s_r.dst_set;
        end
        if (fire && !known) begin
            s_nxt.illegal = 1'b1;
        end else if (fire) begin
            s_nxt.busy      = s_nxt.busy | need_src | need_dst;
            s_nxt.src_set   = need_src;
            s_nxt.dst_set   = need_dst;
            s_nxt.op_valid  = 1'b1;
            s_nxt.op_code   = dec_op;
            s_nxt.op_len    = INS_LEN;
            s_nxt.op_scalar = INS_SCALAR;
            s_nxt.op_mask   = INS_MASK;
            s_nxt.op_count  = INS_COUNT;
            // Cycles until the next instruction may be taken
            s_nxt.holdoff   = ((dec_op == OP_MRG_VV) ? NEXT_VV_CLK : NEXT_CLK) - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link drive and stream pass-through
    assign link.op_valid  = s_r.op_valid;
    assign link.op_code   = s_r.op_code;
    assign link.op_len    = s_r.op_len;
    assign link.op_scalar = s_r.op_scalar;
    assign link.op_mask   = s_r.op_mask;
    assign link.op_count  = s_r.op_count;
    assign link.src_valid = SRC_VALID;
    assign link.src_a     = SRC_A;
    assign link.src_b     = SRC_B;
    assign link.res_ready = RES_READY;
    assign SRC_READY      = link.src_ready;
    assign RES_VALID      = link.res_valid;
    assign RES_DATA       = link.res_data;
    assign RES_LAST       = link.res_last;
    assign ILLEGAL        = s_r.illegal;
    assign REG_BUSY       = s_r.busy;
endmodule : vec_issue

// [testbench/vec_link_sva.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module vec_link_sva
(
    input wire logic                     CLK,
    input wire logic                     SYS_RST,
    input wire logic                     op_valid,
    input wire logic                     op_ready,
    input wire vec_pkg::vop_t            op_code,
    input wire logic [vec_pkg::LEN_W-1:0] op_len,
    input wire logic                     src_valid,
    input wire logic                     src_ready,
    input wire logic                     res_valid,
    input wire logic                     res_ready,
    input wire logic [63:0]              res_data,
    input wire logic                     res_last,
    input wire logic                     lu_busy,
    input wire logic                     su_busy,
    input wire logic                     mask_busy,
    input wire logic                     src_release,
    input wire logic                     dst_ready
);
    import vec_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic             take;
    logic [LEN_W-1:0] len_r;
    logic [LEN_W-1:0] cnt_r;
    assign take = op_valid && op_ready;
    // Pairs taken since the op started
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            len_r <= '0;
            cnt_r <= '0;
        end else if (take) begin
            len_r <= op_len;
            cnt_r <= '0;
        end else if (src_valid && src_ready) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_src_len_limit: assert property (src_valid && src_ready |-> cnt_r < len_r)
        else $error("source pair beyond vector length");
    a_release_all_taken: assert property (src_release |-> cnt_r == len_r)
        else $error("sources released before all pairs taken");
    a_release_early: assert property (take |=> !src_release [*8])
        else $error("sources released too early");
    a_dest_early: assert property (take |=> !dst_ready [*8])
        else $error("destination ready too early");
    a_release_pulse: assert property (src_release |=> !src_release)
        else $error("source release longer than one cycle");
    a_logic_busy: assert property (take && op_code != OP_SHL |=> lu_busy && !su_busy)
        else $error("logical unit not marked busy");
    a_shift_busy: assert property (take && op_code == OP_SHL |=> su_busy && !lu_busy)
        else $error("shift unit not marked busy");
    a_mask_copy: assert property (take && op_code inside {OP_MRG_SV, OP_MRG_VV} |=> mask_busy)
        else $error("mask copy not marked busy");
    a_res_hold: assert property (res_valid && !res_ready |=>
        res_valid && $stable(res_data) && $stable(res_last))
        else $error("result changed while stalled");
    a_unit_frees: assert property (take |-> ##[1:600] op_ready)
        else $error("unit never returned idle");
    c_or_take: cover property (take && op_code == OP_OR);
    c_shift_take: cover property (take && op_code == OP_SHL);
    c_fifo_full: cover property (src_valid && !src_ready && res_valid && !res_ready);
endmodule : vec_link_sva

// [testbench/tb_top.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
    import vec_pkg::*;
    logic              clk, sys_rst, ins_valid, ins_ready, scalar_free, count_free, illegal;
    logic              src_valid, src_ready, res_valid, res_ready, res_last, unit_active;
    logic [8:0]        ins_opcode;
    logic [2:0]        ins_i, ins_j, ins_k;
    logic [LEN_W-1:0]  ins_len, elems_done;
    logic [63:0]       ins_scalar, ins_mask, src_a, src_b, res_data, m_scalar, m_mask;
    logic [CNT_W-1:0]  ins_count, m_count;
    logic [NREG-1:0]   reg_busy;
    logic [63:0]       exp_q[$];
    int                n_errors, checks, seed, cyc, t_take, t_rel, t_dst, n_src, res_idx;
    int                m_op, m_len;
    bit                stall, res_hold, src_hs, got_dst;
    int                lens[3] = '{1, 4, 6};
    logic [CNT_W-1:0]  cnts[6] = '{32'h0, 32'h5, 32'h3F, 32'h40, 32'h41, 32'hFFFFFFFF};
    vec_link_if link();
    vec_issue i_vec_issue (.CLK(clk), .SYS_RST(sys_rst), .link(link), .INS_VALID(ins_valid),
        .INS_READY(ins_ready), .INS_OPCODE(ins_opcode), .INS_I(ins_i), .INS_J(ins_j),
        .INS_K(ins_k), .INS_LEN(ins_len), .INS_SCALAR(ins_scalar), .INS_MASK(ins_mask),
        .INS_COUNT(ins_count), .SCALAR_FREE(scalar_free), .COUNT_FREE(count_free),
        .ILLEGAL(illegal), .SRC_VALID(src_valid), .SRC_READY(src_ready), .SRC_A(src_a),
        .SRC_B(src_b), .RES_VALID(res_valid), .RES_READY(res_ready), .RES_DATA(res_data),
        .RES_LAST(res_last), .REG_BUSY(reg_busy));
    vec_unit i_vec_unit (.CLK(clk), .SYS_RST(sys_rst), .link(link),
        .UNIT_ACTIVE(unit_active), .ELEMS_DONE(elems_done));
    vec_link_sva i_vec_link_sva (.CLK(clk), .SYS_RST(sys_rst), .op_valid(link.op_valid),
        .op_ready(link.op_ready), .op_code(link.op_code), .op_len(link.op_len),
        .src_valid(link.src_valid), .src_ready(link.src_ready), .res_valid(link.res_valid),
        .res_ready(link.res_ready), .res_data(link.res_data), .res_last(link.res_last),
        .lu_busy(link.lu_busy), .su_busy(link.su_busy), .mask_busy(link.mask_busy),
        .src_release(link.src_release), .dst_ready(link.dst_ready));
    initial clk = 1'b0;
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] expv, input logic [63:0] got);
        checks++;
        if (got !== expv) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, expv, got);
        end
    endtask : chk
    task automatic end_sim();
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    function automatic logic [63:0] model(input int e, input logic [63:0] a, input logic [63:0] b);
        case (m_op)
            0: return a | b;
            1: return m_mask[63-e] ? m_scalar : b;
            2: return m_mask[63-e] ? a : b;
            default: return (m_count > 32'h3F) ? 64'h0 : a << m_count[5:0];
        endcase
    endfunction : model
    ////////////////////////////////////////////////////////////////////////////
    // Reference stream, sampled before the edge's updates land
    always @(posedge clk) begin
        cyc++;
        if (cyc > 8000) begin
            n_errors++;
            end_sim();
        end
        if (link.op_valid && link.op_ready) begin
            t_take = cyc;
            n_src = 0;
            res_idx = 0;
        end
        if (link.src_release) t_rel = cyc;
        if (link.dst_ready) begin
            t_dst = cyc;
            got_dst = 1;
        end
        if (src_valid && src_ready) begin
            exp_q.push_back(model(n_src, src_a, src_b));
            n_src++;
            src_hs = 1;
        end
        if (res_valid && res_ready) begin
            chk("res_data", exp_q.size() > 0 ? exp_q.pop_front() : 'x, res_data);
            chk("res_last", 64'(res_idx == m_len - 1), 64'(res_last));
            res_idx++;
        end
    end
    // Pair held until taken; results may stall freely
    always @(negedge clk) begin
        if (src_hs || !src_valid) begin
            src_valid = !stall || $random(seed) % 2;
            src_a = {$random(seed), $random(seed)};
            src_b = {$random(seed), $random(seed)};
        end
        src_hs = 0;
        res_ready = !res_hold && (!stall || $random(seed) % 2);
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic issue_op(input logic [8:0] opc, input int len, input logic [CNT_W-1:0] cnt);
        int n;
        @(negedge clk);
        ins_opcode = opc;
        ins_i = ins_i + 3'h3;
        ins_j = ins_i + 3'h1;
        ins_k = ins_i + 3'h2;
        ins_len = LEN_W'(len);
        ins_scalar = {$random(seed), $random(seed)};
        ins_mask = {$random(seed), $random(seed)};
        ins_count = cnt;
        ins_valid = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ins_ready !== 1'b1 && n < 400);
        chk("ins_ready", 1, ins_ready);
        got_dst = 0;
        m_op = int'(opc) - 'h65;
        m_len = len;
        m_scalar = ins_scalar;
        m_mask = ins_mask;
        m_count = cnt;
        @(negedge clk);
        ins_valid = 1'b0;
        #1;
        chk("reg_busy", 1, reg_busy[ins_i]);
        chk("ins_ready", 0, ins_ready);
    endtask : issue_op
    task automatic wait_done(input bit timed);
        int n;
        n = 0;
        while (!(got_dst && unit_active === 1'b0) && n < 600) begin
            @(negedge clk);
            n++;
        end
        chk("op_done", 1, n < 600);
        chk("elems_done", m_len, elems_done);
        chk("src_taken", m_len, n_src);
        if (timed) begin
            chk("src_free_at", 10 + (m_len > 4 ? m_len - 4 : 0), t_rel - t_take);
            chk("dst_free_at", (m_op == 3 ? 14 : 11) + m_len, t_dst - t_take);
        end
    endtask : wait_done
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_rst, scalar_free, count_free, res_ready} = 4'hF;
        {ins_valid, src_valid, ins_i, ins_j, ins_k, ins_len, ins_count} = '0;
        {ins_scalar, ins_mask, src_a, src_b} = '0;
        ins_opcode = 9'h066;
        seed = 96;
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        scalar_free = 1'b0;
        #1;
        chk("ins_ready", 0, ins_ready);
        @(negedge clk);
        ins_opcode = 9'h068;
        scalar_free = 1'b1;
        count_free = 1'b0;
        #1;
        chk("ins_ready", 0, ins_ready);
        @(negedge clk);
        count_free = 1'b1;
        ins_opcode = 9'h1FF;
        ins_valid = 1'b1;
        @(negedge clk);
        ins_valid = 1'b0;
        chk("illegal", 1, illegal);
        for (int o = 0; o < 4; o++) begin
            for (int l = 0; l < 3; l++) begin
                issue_op(9'h065 + 9'(o), lens[l], cnts[$unsigned($random(seed)) % 6]);
                wait_done(1);
            end
        end
        // Random stalls on both streams, lengths up to the full 64
        stall = 1;
        repeat (8) begin
            issue_op(9'h065 + 9'($unsigned($random(seed)) % 4), 1 + $unsigned($random(seed)) % 64,
                     cnts[$unsigned($random(seed)) % 6]);
            wait_done(0);
        end
        stall = 0;
        res_hold = 1;
        issue_op(9'h065, 20, 32'h0);
        repeat (40) @(negedge clk);
        chk("fifo_fill", 16, n_src);
        chk("src_ready", 0, src_ready);
        res_hold = 0;
        wait_done(0);
        end_sim();
    end
endmodule : tb_top
